// ### common/ssp_pkg.sv
// Shared constants and types for the synchronous serial shift port
package ssp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [31:0] SSP_IDX_RATE_B = 32'hfffff256;
  localparam logic [31:0] SSP_IDX_RATE_A = 32'hfffff257;
  localparam logic [31:0] SSP_IDX_CTRL = 32'hfffff250;
  localparam logic [31:0] SSP_IDX_DATA = 32'hfffff251;
  localparam logic [31:0] SSP_IDX_STAT = 32'hfffff252;
  // Control register fields
  localparam int SSP_CTRL_START = 7;
  localparam int SSP_CTRL_INH = 6;
  localparam int SSP_CTRL_MODE_LO = 4;
  localparam int SSP_CTRL_SEL_LO = 0;
  // Rate register fields
  localparam int SSP_RATE_A_IDLE = 6;
  localparam int SSP_RATE_B_CLKEN = 7;
  // Status register fields
  localparam int SSP_STAT_XFER = 3;
  localparam int SSP_STAT_SHIFT = 2;
  // Mode and clock select encodings
  localparam logic [1:0] SSP_MODE_TX = 2'h0;
  localparam logic [1:0] SSP_MODE_RX = 2'h1;
  localparam logic [1:0] SSP_MODE_TXRX = 2'h2;
  localparam logic [2:0] SSP_SEL_EXT = 3'h7;
  localparam logic [2:0] SSP_BIT_LAST = 3'h7;
  localparam logic [2:0] SSP_BIT_FIRST = 3'h0;
  localparam logic [7:0] SSP_BYTE_ZERO = 8'h00;
  localparam logic [31:0] SSP_WORD_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    SSP_IDLE = 3'h1,
    SSP_SHIFT = 3'h2,
    SSP_WAIT = 3'h4
  } ssp_state_t;

  function automatic logic ssp_hit(input logic [31:0] addr, input logic [31:0] idx);
    return addr == {idx[29:0], 2'h0};
  endfunction
endpackage

// ### rtl/ssp_clk_div.sv
// Internal serial clock divider, seven selectable rates
`timescale 1ns/10ps
module ssp_clk_div
  import ssp_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } ssp_div_st_t;

  ssp_div_st_t st_ff;
  ssp_div_st_t nxt_st;
  logic [CW-1:0] mask;

  // Half period of 2^(sel+1) cycles
  function automatic logic [CW-1:0] half_mask(input logic [2:0] s);
    logic [CW:0] one;
    one = {{CW{1'b0}}, 1'b1};
    return CW'((one << (s + 3'h1)) - one);
  endfunction

  always_comb begin
    mask = half_mask(sel);
    nxt_st.cnt = run ? CW'(st_ff.cnt + 1'b1) : '0;
    nxt_st.tick = run && ((st_ff.cnt & mask) == mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule

// ### rtl/ssp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module ssp_sync
  import ssp_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssp_sync_st_t;

  ssp_sync_st_t st_ff;
  ssp_sync_st_t nxt_st;

  always_comb begin
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2;
endmodule

// ### rtl/ssp_top.sv
// Synchronous serial shift port with APB register access
// Notes on behaviour
// - Select 111 uses external clock pin
// - Internal clock driven out, idles high
// - Internal clock halts while software lags
// - Transmit on falling edge, receive rising
// - Two-bit mode field picks three modes
// - Start loads buffer, shifts out LSB first
// - Load empties buffer, raises empty interrupt
// - Transmit internal clock waits for new data
// - Output holds last bit until first fall
// - Cleared start finishes byte, then flag clears
// - Inhibit aborts at once, clears flag
// - Receive LSB first, buffer full interrupt
// - Receive internal clock waits for read
// - Receive external clock never waits
// - Cleared start completes byte, then flag clears
// - Mode change discards buffer contents
// - Rate bit 7 enables clock, resets 0
// - Status shows transfer and shift flags
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module ssp_top
  import ssp_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic si,
  output logic so,
  output logic buffer_empty_irq,
  output logic buffer_full_irq
);
  typedef struct packed {
    ssp_state_t st;
    logic [7:0] shreg;
    logic [7:0] dbuf;
    logic buf_full;
    logic tx_ready;
    logic [2:0] bitcnt;
    logic start;
    logic inhibit;
    logic [1:0] mode;
    logic [2:0] sel;
    logic idle_en;
    logic clk_en;
    logic sck_out;
    logic sck_oe;
    logic so;
    logic sck_prev;
    logic stop_after;
    logic empty_irq;
    logic full_irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssp_top_st_t;

  ssp_top_st_t st_ff;
  ssp_top_st_t nxt_st;
  logic [1:0] pins_s;
  logic sck_s;
  logic si_s;
  logic tick;
  logic internal;
  logic rise;
  logic fall;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] shifted;
  logic tx_mode;
  logic rx_mode;
  logic byte_end;

  ssp_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({sck_in, si}),
    .dout(pins_s)
  );

  ssp_clk_div #(.CW(DIV_W)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(internal && st_ff.clk_en && st_ff.st == SSP_SHIFT),
    .sel(st_ff.sel),
    .tick(tick)
  );

  assign sck_s = pins_s[1];
  assign si_s = pins_s[0];

  always_comb begin
    nxt_st = st_ff;
    internal = st_ff.sel != SSP_SEL_EXT;
    tx_mode = st_ff.mode != SSP_MODE_RX;
    rx_mode = st_ff.mode != SSP_MODE_TX;
    // Edges of the serial clock, own or external
    fall = internal ? (tick && st_ff.sck_out) : (st_ff.sck_prev && !sck_s);
    rise = internal ? (tick && !st_ff.sck_out) : (!st_ff.sck_prev && sck_s);
    // si lands two cycles late; receive needs select 1 or slower
    shifted = {si_s, st_ff.shreg[7:1]};
    byte_end = 1'b0;
    wr_acc = psel && penable && st_ff.pready && pwrite;
    rd_acc = psel && penable && st_ff.pready && !pwrite;
    nxt_st.sck_prev = sck_s;
    nxt_st.sck_oe = internal;
    nxt_st.empty_irq = 1'b0;
    nxt_st.full_irq = 1'b0;

    // APB setup phase: answer in the following access cycle
    nxt_st.pready = psel && !penable;
    nxt_st.pslverr = 1'b0;
    if (psel && !penable) begin
      nxt_st.prdata = SSP_WORD_ZERO;
      if (ssp_hit(paddr, SSP_IDX_CTRL)) begin
        nxt_st.prdata[SSP_CTRL_START] = st_ff.start;
        nxt_st.prdata[SSP_CTRL_INH] = st_ff.inhibit;
        nxt_st.prdata[SSP_CTRL_MODE_LO +: 2] = st_ff.mode;
        nxt_st.prdata[SSP_CTRL_SEL_LO +: 3] = st_ff.sel;
      end else if (ssp_hit(paddr, SSP_IDX_DATA)) begin
        nxt_st.prdata[7:0] = st_ff.dbuf;
      end else if (ssp_hit(paddr, SSP_IDX_STAT)) begin
        nxt_st.prdata[SSP_STAT_XFER] = st_ff.st != SSP_IDLE;
        nxt_st.prdata[SSP_STAT_SHIFT] = st_ff.st == SSP_SHIFT;
      end else if (ssp_hit(paddr, SSP_IDX_RATE_A)) begin
        nxt_st.prdata[SSP_RATE_A_IDLE] = st_ff.idle_en;
      end else if (ssp_hit(paddr, SSP_IDX_RATE_B)) begin
        nxt_st.prdata[SSP_RATE_B_CLKEN] = st_ff.clk_en;
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end else begin
      nxt_st.pslverr = st_ff.pslverr && psel && penable && !st_ff.pready;
    end

    // Register writes and read side effects
    if (wr_acc && ssp_hit(paddr, SSP_IDX_CTRL)) begin
      nxt_st.start = pwdata[SSP_CTRL_START];
      nxt_st.inhibit = pwdata[SSP_CTRL_INH];
      nxt_st.mode = pwdata[SSP_CTRL_MODE_LO +: 2];
      nxt_st.sel = pwdata[SSP_CTRL_SEL_LO +: 3];
      if (pwdata[SSP_CTRL_MODE_LO +: 2] != st_ff.mode) begin
        nxt_st.buf_full = 1'b0;
        nxt_st.tx_ready = 1'b0;
      end
    end
    if (wr_acc && ssp_hit(paddr, SSP_IDX_DATA)) begin
      nxt_st.dbuf = pwdata[7:0];
      nxt_st.tx_ready = 1'b1;
    end
    if (rd_acc && ssp_hit(paddr, SSP_IDX_DATA)) begin
      nxt_st.buf_full = 1'b0;
    end
    if (wr_acc && ssp_hit(paddr, SSP_IDX_RATE_A)) begin
      nxt_st.idle_en = pwdata[SSP_RATE_A_IDLE];
    end
    if (wr_acc && ssp_hit(paddr, SSP_IDX_RATE_B)) begin
      nxt_st.clk_en = pwdata[SSP_RATE_B_CLKEN];
    end

    // Shift engine; hardware events take priority over bus clears
    case (st_ff.st)
      SSP_IDLE: begin
        nxt_st.sck_out = 1'b1;
        nxt_st.bitcnt = SSP_BIT_FIRST;
        nxt_st.stop_after = 1'b0;
        if (st_ff.start && !st_ff.inhibit) begin
          if (tx_mode) begin
            if (st_ff.tx_ready) begin
              nxt_st.shreg = st_ff.dbuf;
              nxt_st.tx_ready = 1'b0;
              nxt_st.empty_irq = 1'b1;
              nxt_st.st = SSP_SHIFT;
            end
          end else if (internal && st_ff.buf_full) begin
            nxt_st.st = SSP_WAIT;
          end else begin
            nxt_st.st = SSP_SHIFT;
          end
        end
      end
      SSP_SHIFT: begin
        if (internal && tick) begin
          nxt_st.sck_out = !st_ff.sck_out;
        end
        if (fall && tx_mode) begin
          nxt_st.so = st_ff.shreg[0];
        end
        if (rise) begin
          nxt_st.shreg = shifted;
          nxt_st.bitcnt = 3'(st_ff.bitcnt + 3'h1);
          byte_end = st_ff.bitcnt == SSP_BIT_LAST;
        end
        if (byte_end) begin
          if (rx_mode) begin
            nxt_st.dbuf = shifted;
            nxt_st.buf_full = 1'b1;
            nxt_st.full_irq = 1'b1;
          end
          if (!st_ff.start || st_ff.stop_after) begin
            nxt_st.st = SSP_IDLE;
          end else if (internal) begin
            if (tx_mode && st_ff.tx_ready && !rx_mode) begin
              nxt_st.shreg = st_ff.dbuf;
              nxt_st.tx_ready = 1'b0;
              nxt_st.empty_irq = 1'b1;
            end else begin
              nxt_st.st = SSP_WAIT;
            end
          end else if (tx_mode && st_ff.tx_ready) begin
            nxt_st.shreg = st_ff.dbuf;
            nxt_st.tx_ready = 1'b0;
            nxt_st.empty_irq = 1'b1;
          end else if (tx_mode) begin
            nxt_st.stop_after = 1'b1;
          end
        end
      end
      SSP_WAIT: begin
        nxt_st.sck_out = 1'b1;
        if (!st_ff.start) begin
          nxt_st.st = SSP_IDLE;
        end else if (st_ff.mode == SSP_MODE_RX) begin
          if (!st_ff.buf_full) begin
            nxt_st.st = SSP_SHIFT;
          end
        end else if (st_ff.tx_ready && !st_ff.buf_full) begin
          nxt_st.shreg = st_ff.dbuf;
          nxt_st.tx_ready = 1'b0;
          nxt_st.empty_irq = 1'b1;
          nxt_st.st = SSP_SHIFT;
        end
      end
      default: begin
        nxt_st.st = SSP_IDLE;
      end
    endcase

    // Buffer write in a load cycle stays pending
    if (wr_acc && ssp_hit(paddr, SSP_IDX_DATA)) begin
      nxt_st.tx_ready = 1'b1;
    end

    // Abort has the last word
    if (st_ff.inhibit) begin
      nxt_st.st = SSP_IDLE;
      nxt_st.bitcnt = SSP_BIT_FIRST;
      nxt_st.sck_out = 1'b1;
      nxt_st.stop_after = 1'b0;
    end
    if (wr_acc && ssp_hit(paddr, SSP_IDX_CTRL) && pwdata[SSP_CTRL_INH]) begin
      nxt_st.st = SSP_IDLE;
      nxt_st.bitcnt = SSP_BIT_FIRST;
      nxt_st.sck_out = 1'b1;
      nxt_st.full_irq = 1'b0;
      nxt_st.buf_full = st_ff.buf_full && !byte_end;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.st <= SSP_IDLE;
      st_ff.sck_out <= 1'b1;
      st_ff.sck_prev <= 1'b1;
      st_ff.sel <= SSP_SEL_EXT;
      st_ff.shreg <= SSP_BYTE_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign sck_out = st_ff.sck_out;
  assign sck_oe = st_ff.sck_oe;
  assign so = st_ff.so;
  assign buffer_empty_irq = st_ff.empty_irq;
  assign buffer_full_irq = st_ff.full_irq;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_inh_write;
    wr_acc && ssp_hit(paddr, SSP_IDX_CTRL) && pwdata[SSP_CTRL_INH];
  endsequence

  sequence s_tx_load;
    st_ff.st == SSP_IDLE && st_ff.start && !st_ff.inhibit && tx_mode && st_ff.tx_ready
      && !(wr_acc && (ssp_hit(paddr, SSP_IDX_CTRL) || ssp_hit(paddr, SSP_IDX_DATA)));
  endsequence

  chk_sck_oe_select: assert property (
    1'b1 |=> sck_oe == ($past(st_ff.sel) != SSP_SEL_EXT))
    else $error("clock pin enable does not follow clock select");

  chk_sck_idle_high: assert property (
    st_ff.st == SSP_IDLE |-> sck_out)
    else $error("serial clock not high while idle");

  chk_wait_halt: assert property (
    st_ff.st == SSP_WAIT && $past(st_ff.st) == SSP_WAIT |-> sck_out && $stable(sck_out))
    else $error("serial clock moved during wait");

  chk_empty_irq: assert property (
    s_tx_load |=> buffer_empty_irq && !st_ff.tx_ready && st_ff.st == SSP_SHIFT ##1 !buffer_empty_irq)
    else $error("buffer empty pulse missing after load");

  chk_inh_abort: assert property (
    s_inh_write |=> st_ff.st == SSP_IDLE && st_ff.bitcnt == SSP_BIT_FIRST)
    else $error("inhibit did not abort transfer");

  chk_so_hold: assert property (
    $changed(so) |-> $past(fall) && $past(st_ff.st) == SSP_SHIFT)
    else $error("serial output changed off a falling edge");

  chk_full_irq: assert property (
    buffer_full_irq |-> st_ff.buf_full && $past(rise) && $past(st_ff.bitcnt) == SSP_BIT_LAST)
    else $error("buffer full pulse without eighth bit");

  chk_rx_ext_run: assert property (
    st_ff.st == SSP_SHIFT && !internal && st_ff.mode == SSP_MODE_RX && st_ff.start
      && !st_ff.inhibit && !$past(st_ff.stop_after) |=> st_ff.st != SSP_WAIT)
    else $error("wait inserted with external receive clock");

  chk_start_clear: assert property (
    byte_end && !st_ff.start && !st_ff.inhibit |=> st_ff.st == SSP_IDLE)
    else $error("transfer flag not cleared after final byte");
endmodule

// ### tb/ssp_peer.sv
// Serial partner model facing the shift port pins
`timescale 1ns/10ps
module ssp_peer (
  input wire logic sck,
  input wire logic so,
  output logic si,
  output logic ext_sck
);
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  logic [2:0] idx = 3'h0;
  int cnt = 0;

  initial begin
    si = 1'b1;
    ext_sck = 1'b1;
  end

  // Capture on rising edge, LSB first
  always @(posedge sck) begin
    rx_byte <= {so, rx_byte[7:1]};
    cnt <= cnt + 1;
  end

  // Present next bit on falling edge
  always @(negedge sck) begin
    si <= tx_byte[idx];
    idx <= idx + 3'h1;
  end

  // External clock, still between frames
  task automatic gen(input int n);
    repeat (n) begin
      #62.5 ext_sck = 1'b0;
      #62.5 ext_sck = 1'b1;
    end
  endtask
endmodule

// ### tb/tb_ssp_top.sv
// Self-checking testbench for the serial shift port
`timescale 1ns/10ps
module tb_ssp_top;
  import ssp_pkg::*;
  localparam logic [31:0] A_CTRL = {SSP_IDX_CTRL[29:0], 2'h0};
  localparam logic [31:0] A_DATA = {SSP_IDX_DATA[29:0], 2'h0};
  localparam logic [31:0] A_STAT = {SSP_IDX_STAT[29:0], 2'h0};
  localparam logic [31:0] A_RA = {SSP_IDX_RATE_A[29:0], 2'h0};
  localparam logic [31:0] A_RB = {SSP_IDX_RATE_B[29:0], 2'h0};
  localparam logic [31:0] A_BAD = 32'hffffc94c;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sck_out;
  logic sck_oe;
  logic ext_sck;
  logic sck_pin;
  logic si;
  logic so;
  logic empty_irq;
  logic full_irq;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int empty_n = 0;
  int full_n = 0;
  int base;
  int be;

  assign sck_pin = sck_oe ? sck_out : ext_sck;

  ssp_top #(.DIV_W(8)) i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sck_in(sck_pin),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .si(si),
    .so(so),
    .buffer_empty_irq(empty_irq),
    .buffer_full_irq(full_irq)
  );

  ssp_peer i_peer (
    .sck(sck_pin),
    .so(so),
    .si(si),
    .ext_sck(ext_sck)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Pulse counters and hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (empty_irq === 1'b1) empty_n <= empty_n + 1;
    if (full_irq === 1'b1) full_n <= full_n + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and register access
    rdc(A_RB, 32'h0, "rate_b reset");
    rdc(A_STAT, 32'h0, "status reset");
    chk({31'h0, sck_oe}, 32'h0, "sck_oe ext");
    wr(A_RA, 32'h40);
    rdc(A_RA, 32'h40, "rate_a");
    apb(1'b0, A_BAD, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    // Internal clock transmit with wait
    wr(A_RB, 32'h80);
    wr(A_CTRL, 32'h00);
    wait_cyc(2);
    chk({30'h0, sck_oe, sck_out}, 32'h3, "sck drive idle");
    wr(A_DATA, 32'ha5);
    base = i_peer.cnt;
    be = empty_n;
    wr(A_CTRL, 32'h80);
    while (i_peer.cnt < base + 8) @(posedge pclk);
    wait_cyc(40);
    chk(32'(i_peer.cnt - base), 32'h8, "tx halted");
    chk({24'h0, i_peer.rx_byte}, 32'ha5, "tx byte");
    chk(32'(empty_n - be), 32'h1, "empty irq");
    rdc(A_STAT, 32'h8, "status wait");
    wr(A_DATA, 32'h3c);
    chk({31'h0, so}, 32'h1, "so hold");
    wr(A_CTRL, 32'h00);
    while (i_peer.cnt < base + 16) @(posedge pclk);
    wait_cyc(20);
    chk({24'h0, i_peer.rx_byte}, 32'h3c, "tx byte 2");
    rdc(A_STAT, 32'h0, "tx ended");
    // Internal clock receive
    i_peer.tx_byte = 8'h96;
    i_peer.idx = 3'h0;
    base = full_n;
    wr(A_CTRL, 32'h91);
    while (full_n == base) @(posedge pclk);
    be = i_peer.cnt;
    wait_cyc(40);
    chk(32'(i_peer.cnt - be), 32'h0, "rx halted");
    rdc(A_DATA, 32'h96, "rx byte");
    wr(A_CTRL, 32'h11);
    while (full_n == base + 1) @(posedge pclk);
    rdc(A_DATA, 32'h96, "rx last");
    rdc(A_STAT, 32'h0, "rx ended");
    // Internal clock transmit and receive together
    wr(A_CTRL, 32'h21);
    wr(A_DATA, 32'h4b);
    i_peer.tx_byte = 8'hd2;
    i_peer.idx = 3'h0;
    base = full_n;
    wr(A_CTRL, 32'ha1);
    while (full_n == base) @(posedge pclk);
    chk({24'h0, i_peer.rx_byte}, 32'h4b, "txrx out");
    rdc(A_STAT, 32'h8, "txrx wait");
    rdc(A_DATA, 32'hd2, "txrx in");
    wr(A_CTRL, 32'h21);
    rdc(A_STAT, 32'h0, "txrx ended");
    // External clock receive and abort
    wr(A_CTRL, 32'h97);
    wait_cyc(2);
    chk({31'h0, sck_oe}, 32'h0, "sck released");
    i_peer.tx_byte = 8'h5a;
    i_peer.idx = 3'h0;
    base = full_n;
    i_peer.gen(8);
    wait_cyc(8);
    chk(32'(full_n - base), 32'h1, "ext rx 1");
    i_peer.tx_byte = 8'hc3;
    i_peer.gen(8);
    wait_cyc(8);
    chk(32'(full_n - base), 32'h2, "ext rx 2");
    rdc(A_DATA, 32'hc3, "ext overrun");
    i_peer.gen(3);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h8, 32'h8, "busy mid byte");
    wr(A_CTRL, 32'hd7);
    rdc(A_STAT, 32'h0, "aborted");
    i_peer.gen(5);
    wait_cyc(8);
    chk(32'(full_n - base), 32'h2, "no partial");
    // Counter restarts after the abort
    wr(A_CTRL, 32'h97);
    i_peer.tx_byte = 8'h3a;
    i_peer.idx = 3'h0;
    i_peer.gen(8);
    wait_cyc(8);
    chk(32'(full_n - base), 32'h3, "rx after abort");
    rdc(A_DATA, 32'h3a, "rx restart byte");
    // External clock transmit, refill then stop
    wr(A_CTRL, 32'h57);
    wr(A_CTRL, 32'h07);
    wr(A_DATA, 32'h69);
    be = empty_n;
    wr(A_CTRL, 32'h87);
    wr(A_DATA, 32'h1e);
    i_peer.gen(8);
    wait_cyc(8);
    chk({24'h0, i_peer.rx_byte}, 32'h69, "ext tx 1");
    wr(A_CTRL, 32'h07);
    i_peer.gen(8);
    wait_cyc(8);
    chk({24'h0, i_peer.rx_byte}, 32'h1e, "ext tx 2");
    chk(32'(empty_n - be), 32'h2, "ext empty irq");
    rdc(A_STAT, 32'h0, "ext tx ended");
    finish_test();
  end
endmodule
